// >>> core/edl_loader.sv
// Divider shadow loader with lock logic behind an AHB-Lite register slave.
module edl_loader (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic      [1:0]  hresp,
  output logic      [10:0] timebase_divisor,
  output logic             lock_disable_bit
);

  // Bus-side state.
  edl_pkg::edl_state_e state_reg;
  edl_pkg::edl_state_e state_next;
  edl_pkg::edl_req_s   req_reg;
  edl_pkg::edl_req_s   req_next;
  logic [31:0]         hrdata_reg;
  logic [31:0]         hrdata_next;
  logic                hreadyout_reg;
  logic                hreadyout_next;
  logic [1:0]          hresp_reg;

  // Live divider registers, control and status.
  logic [7:0] high_live_reg;
  logic [7:0] high_live_next;
  logic [7:0] low_live_reg;
  logic [7:0] low_live_next;
  logic       latch_reg;
  logic       latch_next;
  logic       erase_reg;
  logic       erase_next;
  logic       reject_reg;
  logic       reject_next;

  // Shadow access strobes and contents.
  logic       prog_en;
  logic       prog_high;
  logic [7:0] shadow_high;
  logic [7:0] shadow_low;

  // Decoded data-phase writes.
  logic wr_phase;
  logic live_wr_hi;
  logic live_wr_lo;
  logic shadow_wr;
  logic live_open;
  logic new_req;

  // Reads are answered from registered state so the data never races a write.
  function automatic logic [7:0] read_mux(input logic [7:0] addr, input logic [7:0] hi, input logic [7:0] lo,
                                          input logic [7:0] shi, input logic [7:0] slo, input logic lat,
                                          input logic era, input logic rej);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      edl_pkg::OFF_HIGH_LIVE:   v = hi;
      edl_pkg::OFF_LOW_LIVE:    v = lo;
      edl_pkg::OFF_HIGH_SHADOW: v = shi;
      edl_pkg::OFF_LOW_SHADOW:  v = slo;
      edl_pkg::OFF_CTRL: begin
        v[edl_pkg::LATCH_POS] = lat;
        v[edl_pkg::ERASE_POS] = era;
      end
      edl_pkg::OFF_STATUS: begin
        v[edl_pkg::REJECT_POS] = rej;
        v[edl_pkg::ARMED_POS]  = ~hi[edl_pkg::LOCK_POS];
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  edl_shadow u_shadow (
    .hclk      (hclk),
    .prog_en   (prog_en),
    .prog_high (prog_high),
    .erase     (erase_reg),
    .prog_data (hwdata[7:0]),
    .high_q    (shadow_high),
    .low_q     (shadow_low)
  );

  // Data-phase decode. Lock bit one means software may touch the divider.
  assign wr_phase   = (state_reg != edl_pkg::EDL_LOAD) && req_reg.valid && req_reg.write;
  assign live_open  = high_live_reg[edl_pkg::LOCK_POS] && !latch_reg;
  assign live_wr_hi = wr_phase && (req_reg.addr == edl_pkg::OFF_HIGH_LIVE);
  assign live_wr_lo = wr_phase && (req_reg.addr == edl_pkg::OFF_LOW_LIVE);
  assign shadow_wr  = wr_phase && ((req_reg.addr == edl_pkg::OFF_HIGH_SHADOW) ||
                                   (req_reg.addr == edl_pkg::OFF_LOW_SHADOW));
  assign prog_en    = shadow_wr && high_live_reg[edl_pkg::LOCK_POS];
  assign prog_high  = (req_reg.addr == edl_pkg::OFF_HIGH_SHADOW);
  assign new_req    = hsel && hready && htrans[1];

  // Next-state logic for the sequence, the bus answer and the registers.
  always_comb begin
    state_next     = state_reg;
    req_next       = req_reg;
    hrdata_next    = hrdata_reg;
    hreadyout_next = hreadyout_reg;
    high_live_next = high_live_reg;
    low_live_next  = low_live_reg;
    latch_next     = latch_reg;
    erase_next     = erase_reg;
    reject_next    = reject_reg;
    case (state_reg)
      edl_pkg::EDL_LOAD: begin
        // The only path from shadow to live; it runs once per reset.
        high_live_next = shadow_high & edl_pkg::HIGH_MASK;
        low_live_next  = shadow_low;
        hreadyout_next = 1'b1;
        state_next     = edl_pkg::EDL_IDLE;
      end
      edl_pkg::EDL_IDLE: begin
        if (live_wr_hi && live_open) begin
          high_live_next = hwdata[7:0] & edl_pkg::HIGH_MASK;
        end
        if (live_wr_lo && live_open) begin
          low_live_next = hwdata[7:0];
        end
        if (wr_phase && (req_reg.addr == edl_pkg::OFF_CTRL)) begin
          latch_next = hwdata[edl_pkg::LATCH_POS];
          erase_next = hwdata[edl_pkg::ERASE_POS];
        end
        // Write one clears the reject flag; a new rejection in that cycle wins.
        if (wr_phase && (req_reg.addr == edl_pkg::OFF_STATUS) && hwdata[edl_pkg::REJECT_POS]) begin
          reject_next = 1'b0;
        end
        if (shadow_wr && !high_live_reg[edl_pkg::LOCK_POS]) begin
          reject_next = 1'b1;
        end
        if (new_req) begin
          req_next = '{valid: 1'b1, write: hwrite, addr: haddr[7:0]};
          if (!hwrite) begin
            hreadyout_next = 1'b0;
            state_next     = edl_pkg::EDL_RWAIT;
          end
        end else if (hready) begin
          req_next.valid = 1'b0;
        end
      end
      edl_pkg::EDL_RWAIT: begin
        hrdata_next    = {24'h00_0000, read_mux(req_reg.addr, high_live_reg, low_live_reg, shadow_high,
                                                shadow_low, latch_reg, erase_reg, reject_reg)};
        hreadyout_next = 1'b1;
        req_next.valid = 1'b0;
        state_next     = edl_pkg::EDL_IDLE;
      end
      default: state_next = edl_pkg::EDL_IDLE;
    endcase
  end

  // Registers; the bus stalls during the load cycle after reset release.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg     <= edl_pkg::EDL_LOAD;
      req_reg       <= '0;
      hrdata_reg    <= edl_pkg::RDATA_RST;
      hreadyout_reg <= 1'b0;
      hresp_reg     <= edl_pkg::RESP_OKAY;
      high_live_reg <= edl_pkg::HIGH_LIVE_RST;
      low_live_reg  <= edl_pkg::LOW_LIVE_RST;
      latch_reg     <= 1'b0;
      erase_reg     <= 1'b0;
      reject_reg    <= 1'b0;
    end else begin
      state_reg     <= state_next;
      req_reg       <= req_next;
      hrdata_reg    <= hrdata_next;
      hreadyout_reg <= hreadyout_next;
      hresp_reg     <= edl_pkg::RESP_OKAY;
      high_live_reg <= high_live_next;
      low_live_reg  <= low_live_next;
      latch_reg     <= latch_next;
      erase_reg     <= erase_next;
      reject_reg    <= reject_next;
    end
  end

  assign hrdata           = hrdata_reg;
  assign hreadyout        = hreadyout_reg;
  assign hresp            = hresp_reg;
  assign timebase_divisor = {high_live_reg[2:0], low_live_reg};
  assign lock_disable_bit = high_live_reg[edl_pkg::LOCK_POS];

  // Checks on the loader, the lock and the bus answer.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_rd_issue;
    (state_reg == edl_pkg::EDL_IDLE) && new_req && !hwrite;
  endsequence

  sequence s_rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence

  a_shadow_hold: assert property (!prog_en |=> $stable(shadow_high) && $stable(shadow_low))
    else $error("shadow bytes changed without a program strobe");

  // The sampled reset input keeps the edge that releases reset from counting as the load cycle.
  a_reset_copy: assert property (hresetn && (state_reg == edl_pkg::EDL_LOAD) |=>
      (low_live_reg == $past(shadow_low)) && (high_live_reg == ($past(shadow_high) & edl_pkg::HIGH_MASK)))
    else $error("live registers not loaded from shadow");

  a_no_early_copy: assert property ((state_reg != edl_pkg::EDL_LOAD) && !live_wr_hi && !live_wr_lo |=>
      $stable(high_live_reg) && $stable(low_live_reg))
    else $error("live divider changed without reset or write");

  a_lock_sticks: assert property (hresetn && (state_reg == edl_pkg::EDL_LOAD) && !shadow_high[edl_pkg::LOCK_POS] |=>
      !lock_disable_bit ##1 !lock_disable_bit)
    else $error("lock did not stay armed after load");

  a_prog_reject: assert property (shadow_wr && !high_live_reg[edl_pkg::LOCK_POS] |-> !prog_en ##1 reject_reg)
    else $error("locked shadow write not rejected");

  a_prog_allow: assert property (shadow_wr && high_live_reg[edl_pkg::LOCK_POS] |-> prog_en)
    else $error("unlocked shadow write not performed");

  a_live_frozen: assert property ((state_reg != edl_pkg::EDL_LOAD) && !high_live_reg[edl_pkg::LOCK_POS] |=>
      $stable(high_live_reg) && $stable(low_live_reg))
    else $error("locked live register changed");

  a_latch_block: assert property (live_wr_lo && latch_reg |=> $stable(low_live_reg))
    else $error("live write accepted while latch set");

  a_erase_ones: assert property (prog_en && erase_reg && prog_high |=> shadow_high == edl_pkg::ERASED_BYTE)
    else $error("erased shadow byte not all ones");

  a_read_wait: assert property (s_rd_issue |=> s_rd_answer)
    else $error("read answer not after one wait state");

endmodule

// >>> core/edl_shadow.sv
// Non-volatile shadow byte pair with byte program and byte erase.
module edl_shadow (
  input  wire logic       hclk,
  input  wire logic       prog_en,
  input  wire logic       prog_high,
  input  wire logic       erase,
  input  wire logic [7:0] prog_data,
  output logic      [7:0] high_q,
  output logic      [7:0] low_q
);

  // Model of a fresh part: the cells start erased. No reset reaches them.
  // The start value sits in the declaration so that the clocked process stays the only writer.
  logic [7:0] high_reg = edl_pkg::ERASED_BYTE;
  logic [7:0] low_reg  = edl_pkg::ERASED_BYTE;
  logic [7:0] high_next;
  logic [7:0] low_next;

  // Programming only clears bits, as an EEPROM cell does; erase restores ones.
  always_comb begin
    high_next = high_reg;
    low_next  = low_reg;
    if (prog_en) begin
      if (prog_high) begin
        high_next = erase ? edl_pkg::ERASED_BYTE : (high_reg & prog_data);
      end else begin
        low_next = erase ? edl_pkg::ERASED_BYTE : (low_reg & prog_data);
      end
    end
  end

  // Storage is deliberately outside every reset domain.
  always_ff @(posedge hclk) begin
    high_reg <= high_next;
    low_reg  <= low_next;
  end

  assign high_q = high_reg;
  assign low_q  = low_reg;

endmodule

// >>> inc/edl_pkg.sv
// Package with the constants and types of the divider shadow loader.
package edl_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFF_HIGH_LIVE   = 8'h00;
  localparam logic [7:0] OFF_LOW_LIVE    = 8'h04;
  localparam logic [7:0] OFF_HIGH_SHADOW = 8'h08;
  localparam logic [7:0] OFF_LOW_SHADOW  = 8'h0C;
  localparam logic [7:0] OFF_CTRL        = 8'h10;
  localparam logic [7:0] OFF_STATUS      = 8'h14;

  // Field positions inside the high byte and the control and status words.
  localparam int unsigned LOCK_POS    = 7;
  localparam int unsigned LATCH_POS   = 0;
  localparam int unsigned ERASE_POS   = 1;
  localparam int unsigned REJECT_POS  = 0;
  localparam int unsigned ARMED_POS   = 1;
  localparam logic [7:0]  HIGH_MASK   = 8'h87;

  // Values after reset and the erased pattern of a shadow byte.
  localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
  localparam logic [7:0]  HIGH_LIVE_RST = 8'h87;
  localparam logic [7:0]  LOW_LIVE_RST  = 8'hFF;
  localparam logic [31:0] RDATA_RST     = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;

  // One captured bus address phase.
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } edl_req_s;

  // Loader sequence: load after reset, serve the bus, or wait on a read.
  typedef enum logic [1:0] {
    EDL_LOAD,
    EDL_IDLE,
    EDL_RWAIT
  } edl_state_e;

endpackage

// >>> tb/edl_loader_tb.sv
// Self-checking testbench of the divider shadow loader on its register bus.
module edl_loader_tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
  } edl_row_s;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [1:0]  hresp;
  logic [10:0] timebase_divisor;
  logic        lock_disable_bit;
  int          err_count;
  int          n_compared;
  logic [31:0] rd;
  edl_row_s    rows [4];

  // The only slave drives the bus ready, so its ready output loops back.
  edl_loader i_dut (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .hsel             (hsel),
    .haddr            (haddr),
    .htrans           (htrans),
    .hwrite           (hwrite),
    .hsize            (hsize),
    .hwdata           (hwdata),
    .hready           (hreadyout),
    .hrdata           (hrdata),
    .hreadyout        (hreadyout),
    .hresp            (hresp),
    .timebase_divisor (timebase_divisor),
    .lock_disable_bit (lock_disable_bit)
  );

  // Free-running bus clock of 5 ns.
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("Compared %0d values, %0d mismatches.", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Waits for ready sampled high at a rising edge, with a bound so a stuck slave cannot hang us.
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 20) begin
      n++;
      @(posedge hclk);
    end
    if (n == 20) begin
      check("hready", {31'h0, hreadyout}, 32'h0000_0001);
    end
  endtask

  // One single word transfer; called right after a rising edge.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    check("hresp", {30'h0, hresp}, 32'h0000_0000);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(what, rd, exp);
  endtask

  // Reset held for 16 cycles; live values are checked while it is held.
  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    check("divisor in reset", {21'h0, timebase_divisor}, 32'h0000_07FF);
    check("lock in reset", {31'h0, lock_disable_bit}, 32'h0000_0001);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask

  // Watchdog sized well above the few hundred cycles the tests need.
  initial begin
    #100us;
    err_count++;
    end_sim();
  end

  // Main sequence; the lock is armed last because it can never be lifted.
  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h0000_0000;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hsize   = 3'b010;
    hwdata  = 32'h0000_0000;
    err_count  = 0;
    n_compared = 0;
    rows[0] = '{8'h00, 32'h0000_0085, 32'h0000_0085};
    rows[1] = '{8'h04, 32'h0000_003C, 32'h0000_003C};
    rows[2] = '{8'h0C, 32'h0000_00F0, 32'h0000_00F0};
    rows[3] = '{8'h18, 32'h0000_00AA, 32'h0000_0000};
    do_reset();
    check("lock after load", {31'h0, lock_disable_bit}, 32'h0000_0001);
    check("divisor after load", {21'h0, timebase_divisor}, 32'h0000_07FF);
    rchk("high live", 8'h00, 32'h0000_0087);
    rchk("high shadow", 8'h08, 32'h0000_00FF);
    rchk("low shadow", 8'h0C, 32'h0000_00FF);
    rchk("status", 8'h14, 32'h0000_0000);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rchk("row read", rows[i].addr, rows[i].rdata);
    end
    check("divisor written", {21'h0, timebase_divisor}, 32'h0000_053C);
    $display("test table done");
    // With the latch bit set the live divisor must refuse writes.
    wr(8'h10, 32'h0000_0001);
    wr(8'h04, 32'h0000_0011);
    rchk("low live latched", 8'h04, 32'h0000_003C);
    wr(8'h10, 32'h0000_0000);
    $display("test latch done");
    do_reset();
    check("divisor reloaded", {21'h0, timebase_divisor}, 32'h0000_07F0);
    rchk("low shadow kept", 8'h0C, 32'h0000_00F0);
    // Programming only clears bits, so the high byte is erased again before its final value.
    wr(8'h08, 32'h0000_00FE);
    rchk("high shadow programmed", 8'h08, 32'h0000_00FE);
    wr(8'h10, 32'h0000_0002);
    wr(8'h0C, 32'h0000_0000);
    wr(8'h08, 32'h0000_0000);
    wr(8'h10, 32'h0000_0000);
    rchk("low shadow erased", 8'h0C, 32'h0000_00FF);
    rchk("high shadow erased", 8'h08, 32'h0000_00FF);
    $display("test reload and erase done");
    // The high shadow value is read back before the next reset makes it final.
    wr(8'h08, 32'h0000_007F);
    rchk("high shadow set", 8'h08, 32'h0000_007F);
    check("lock before reset", {31'h0, lock_disable_bit}, 32'h0000_0001);
    do_reset();
    check("lock armed", {31'h0, lock_disable_bit}, 32'h0000_0000);
    rchk("high live locked", 8'h00, 32'h0000_0007);
    wr(8'h04, 32'h0000_0000);
    rchk("low live locked", 8'h04, 32'h0000_00FF);
    wr(8'h00, 32'h0000_0087);
    rchk("high live frozen", 8'h00, 32'h0000_0007);
    wr(8'h10, 32'h0000_0002);
    wr(8'h08, 32'h0000_0000);
    rchk("high shadow locked", 8'h08, 32'h0000_007F);
    rchk("status reject", 8'h14, 32'h0000_0003);
    // Clear the sticky reject flag, then try a plain program of the low shadow byte.
    wr(8'h14, 32'h0000_0001);
    rchk("status cleared", 8'h14, 32'h0000_0002);
    wr(8'h10, 32'h0000_0000);
    wr(8'h0C, 32'h0000_0000);
    rchk("low shadow locked", 8'h0C, 32'h0000_00FF);
    rchk("status program reject", 8'h14, 32'h0000_0003);
    do_reset();
    check("lock permanent", {31'h0, lock_disable_bit}, 32'h0000_0000);
    rchk("high shadow survives", 8'h08, 32'h0000_007F);
    $display("test lock done");
    end_sim();
  end

endmodule
